/* rtl/ibcs_seq.sv */
// Top: sequences the bus cycles issued while executing one instruction
//
// Behaviour
// - Every issued cycle is a byte or word read.
// - A locked cycle holds mastership into the next cycle; no handover.
// - Extension words are fetched at sequential word addresses after the opcode.
// - The last fetch of every non-branch instruction reads the next instruction address; a branch ends on its ea read.
// - Register add, extended add, byte logic: one read at next address.
// - 16-bit immediate word op: read second word, then next address.
// - 32-bit immediate long op: read second, third word, then next address.
// - Longword register AND: second word then next; long add one read.
// - AND into extended control reg: two reads; condition code reg: one.
// - Indirect or 8-bit bit test: second word, byte at ea, locked next.
// - 16/32-bit absolute bit test adds third, fourth word before byte read.
// - 8-bit branch: read next address, then read at effective address.
// - Never-taken branch issues the same two reads as a taken one.
// - 16-bit branch: second word, one internal state, then ea read.
`timescale 1ns/1ps
`default_nettype none

module ibcs_seq (
   input  wire logic        core_clk,     // System clock, 100 MHz
   input  wire logic        rst_n,        // Async reset, active low
   input  wire logic        start,        // Begin an instruction, one-cycle pulse
   input  wire logic [3:0]  op_class,     // Instruction class
   input  wire logic [23:0] start_addr,   // Address of the opcode word
   input  wire logic [23:0] effective_address, // Operand or branch target
   input  wire logic        cycle_done,   // Memory ends the current cycle
   input  wire logic        bus_req,      // Other master asks for the bus
   output logic             busy,         // Instruction in progress
   output logic             cyc_valid,    // Bus cycle requested
   output logic [1:0]       cyc_kind,     // Byte/word read/write
   output logic [23:0]      cyc_addr,     // Cycle address
   output logic             cyc_lock,     // Cycle locked
   output logic             internal_op,  // Internal state, no bus access
   output logic             bus_grant,    // Bus handed to the other master
   output logic             instr_done    // Instruction finished, pulse
);

   // ****************************************
   // State
   // ****************************************
   typedef enum logic [1:0] {IBCS_IDLE, IBCS_BUS, IBCS_INT, IBCS_GRANT} ibcs_state_t;

   ibcs_state_t state, next_state;
   logic [3:0]  op, next_op;
   logic [2:0]  idx, next_idx;
   logic [23:0] ext_addr, next_ext_addr;
   logic [23:0] nxt_addr, next_nxt_addr;
   logic [23:0] ea, next_ea;
   logic        next_busy, next_cyc_valid, next_cyc_lock, next_internal_op;
   logic        next_bus_grant, next_instr_done, held_lock, next_held_lock;
   logic [1:0]  next_cyc_kind;
   logic [23:0] next_cyc_addr;

   logic [3:0]  dec_op;
   logic [2:0]  dec_idx;
   logic        s_act, s_idle, s_lock;
   logic [1:0]  s_src;
   logic [1:0]  c_src;
   logic        c_last;

   // Step being finished; a shared decoder would loop through its own index
   ibcs_step u_step_cur (
      .op   (op),
      .idx  (idx),
      .act  (),
      .idle (),
      .src  (c_src),
      .lock (),
      .last (c_last)
   );

   // Step to issue next
   ibcs_step u_step (
      .op   (dec_op),
      .idx  (dec_idx),
      .act  (s_act),
      .idle (s_idle),
      .src  (s_src),
      .lock (s_lock),
      .last ()
   );

   always_comb begin
      dec_op  = (state == IBCS_IDLE) ? op_class : op;
      dec_idx = (state == IBCS_IDLE) ? 3'd0 : idx + 3'd1;
   end

   function automatic logic [23:0] pick_addr(input logic [1:0] s, input logic [23:0] e,
                                              input logic [23:0] a, input logic [23:0] n);
      pick_addr = (s == 2'd0) ? e : (s == 2'd1) ? a : n;
   endfunction

   // Fetch lengths: register op and condition code AND are one word; other immediates, longword AND and bit ops longer
   function automatic logic [23:0] next_of(input logic [3:0] o, input logic [23:0] a);
      logic [2:0] words;
      words = 3'd1;
      unique case (ibcs_pkg::ibcs_op_t'(o))
         ibcs_pkg::IBCS_OP_IMM16, ibcs_pkg::IBCS_OP_AND_L, ibcs_pkg::IBCS_OP_AND_INTO_CONTROL_REGISTER_EXT,
         ibcs_pkg::IBCS_OP_BIT_IND, ibcs_pkg::IBCS_OP_BIT_A8, ibcs_pkg::IBCS_OP_BR16: words = 3'd2;
         ibcs_pkg::IBCS_OP_IMM32, ibcs_pkg::IBCS_OP_BIT_A16: words = 3'd3;
         ibcs_pkg::IBCS_OP_BIT_A32: words = 3'd4;
         default: words = 3'd1;
      endcase
      next_of = a + {20'h0_0000, words, 1'b0};
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_state       = state;
      next_op          = op;
      next_idx         = idx;
      next_ext_addr    = ext_addr;
      next_nxt_addr    = nxt_addr;
      next_ea          = ea;
      next_busy        = busy;
      next_cyc_valid   = cyc_valid;
      next_cyc_kind    = cyc_kind;
      next_cyc_addr    = cyc_addr;
      next_cyc_lock    = cyc_lock;
      next_internal_op = 1'b0;
      next_bus_grant   = 1'b0;
      next_instr_done  = 1'b0;
      next_held_lock   = held_lock;
      unique case (state)
         IBCS_IDLE: begin
            if (start) begin
               next_op       = op_class;
               next_idx      = 3'd0;
               next_ea       = effective_address;
               next_nxt_addr = next_of(op_class, start_addr);
               next_ext_addr = start_addr + ibcs_pkg::IBCS_WORD_STEP;
               next_busy     = 1'b1;
               next_cyc_valid = 1'b1;
               // Only reads are issued by the listed classes
               next_cyc_kind = ibcs_pkg::IBCS_RD_WORD;
               next_cyc_lock = s_lock;
               next_cyc_addr = pick_addr(s_src, start_addr + ibcs_pkg::IBCS_WORD_STEP,
                                         effective_address, next_of(op_class, start_addr));
               next_state    = IBCS_BUS;
            end else if (bus_req && !held_lock) begin
               next_bus_grant = 1'b1;
               next_state     = IBCS_GRANT;
            end
         end
         IBCS_GRANT: begin
            next_bus_grant = bus_req;
            if (!bus_req) begin
               next_state = IBCS_IDLE;
            end
         end
         IBCS_INT, IBCS_BUS: begin
            // Memory sets the state count per cycle; this only waits for done
            if (state == IBCS_INT || cycle_done) begin
               next_held_lock = (state == IBCS_BUS) ? cyc_lock : held_lock;
               if (state == IBCS_BUS && c_src == 2'd0) begin
                  next_ext_addr = ext_addr + ibcs_pkg::IBCS_WORD_STEP;
               end
               if (c_last) begin
                  // Final fetch was the next-address read, or the ea read for a branch
                  next_cyc_valid  = 1'b0;
                  next_cyc_lock   = 1'b0;
                  next_busy       = 1'b0;
                  next_instr_done = 1'b1;
                  next_state      = IBCS_IDLE;
               end else begin
                  next_idx = idx + 3'd1;
                  next_cyc_addr = pick_addr(s_src, (state == IBCS_BUS && c_src == 2'd0) ?
                                            ext_addr + ibcs_pkg::IBCS_WORD_STEP : ext_addr, ea, nxt_addr);
                  // Bit test operand byte read, then locked next read
                  next_cyc_kind = (s_src == 2'd1 && op >= ibcs_pkg::IBCS_OP_BIT_IND &&
                                   op <= ibcs_pkg::IBCS_OP_BIT_A32) ?
                                  ibcs_pkg::IBCS_RD_BYTE : ibcs_pkg::IBCS_RD_WORD;
                  next_cyc_lock    = s_lock;
                  next_cyc_valid   = s_act;
                  next_internal_op = s_idle;
                  next_state       = s_idle ? IBCS_INT : IBCS_BUS;
               end
            end
         end
      endcase
      if (state == IBCS_IDLE && !start && held_lock) begin
         next_held_lock = 1'b0;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= IBCS_IDLE;
         op          <= 4'h0;
         idx         <= 3'h0;
         ext_addr    <= ibcs_pkg::IBCS_RESET_ADDR;
         nxt_addr    <= ibcs_pkg::IBCS_RESET_ADDR;
         ea          <= ibcs_pkg::IBCS_RESET_ADDR;
         busy        <= 1'b0;
         cyc_valid   <= 1'b0;
         cyc_kind    <= ibcs_pkg::IBCS_RD_WORD;
         cyc_addr    <= ibcs_pkg::IBCS_RESET_ADDR;
         cyc_lock    <= 1'b0;
         internal_op <= 1'b0;
         bus_grant   <= 1'b0;
         instr_done  <= 1'b0;
         held_lock   <= 1'b0;
      end else begin
         state       <= next_state;
         op          <= next_op;
         idx         <= next_idx;
         ext_addr    <= next_ext_addr;
         nxt_addr    <= next_nxt_addr;
         ea          <= next_ea;
         busy        <= next_busy;
         cyc_valid   <= next_cyc_valid;
         cyc_kind    <= next_cyc_kind;
         cyc_addr    <= next_cyc_addr;
         cyc_lock    <= next_cyc_lock;
         internal_op <= next_internal_op;
         bus_grant   <= next_bus_grant;
         instr_done  <= next_instr_done;
         held_lock   <= next_held_lock;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_lock_no_grant: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cyc_valid && cyc_lock && cycle_done) |=> !bus_grant)
      else $error("grant right after locked cycle");
   chk_done_after_next: assert property (@(posedge core_clk) disable iff (!rst_n)
      instr_done |-> $past(cyc_valid) && $past(cyc_kind) == 2'h1 &&
         $past(cyc_addr) == ((op == ibcs_pkg::IBCS_OP_BR8 || op == ibcs_pkg::IBCS_OP_BR16) ? ea : nxt_addr))
      else $error("instruction did not end on next-address word read");
   chk_lock_is_word: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cyc_valid && cyc_lock) |-> cyc_kind == 2'h1 && cyc_addr == nxt_addr)
      else $error("locked cycle not a word read of next address");
   chk_internal_no_bus: assert property (@(posedge core_clk) disable iff (!rst_n)
      internal_op |-> !cyc_valid ##1 cyc_valid && cyc_addr == ea)
      else $error("internal state misplaced");
   chk_read_only: assert property (@(posedge core_clk) disable iff (!rst_n)
      cyc_valid |-> cyc_kind inside {2'h0, 2'h1})
      else $error("unexpected cycle kind");
   chk_reg_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cyc_valid && cycle_done && op == ibcs_pkg::IBCS_OP_REG) |=> instr_done && !cyc_valid)
      else $error("register op took more than one cycle");
   chk_byte_at_ea: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cyc_valid && cyc_kind == 2'h0) |-> cyc_addr == ea)
      else $error("byte read not at effective address");
   chk_br8_order: assert property (@(posedge core_clk) disable iff (!rst_n)
      (start && state == IBCS_IDLE && op_class == 4'hA) |=> cyc_addr == nxt_addr && cyc_kind == 2'h1)
      else $error("short branch did not fetch next first");

endmodule

`default_nettype wire

/* rtl/ibcs_pkg.sv */
// Package: constants and types for the instruction bus cycle sequencer
package ibcs_pkg;

   // Instruction classes the core hands to the sequencer
   typedef enum logic [3:0] {
      IBCS_OP_REG      = 4'h0,  // One-word register op, next fetch only
      IBCS_OP_IMM16    = 4'h1,  // Word op with 16-bit immediate
      IBCS_OP_IMM32    = 4'h2,  // Longword op with 32-bit immediate
      IBCS_OP_AND_L    = 4'h3,  // Longword register AND
      IBCS_OP_AND_INTO_CONTROL_REGISTER_EXT = 4'h4,  // Immediate AND into extended control reg
      IBCS_OP_AND_INTO_CONTROL_REGISTER_CC  = 4'h5,  // Immediate AND into condition code reg
      IBCS_OP_BIT_IND  = 4'h6,  // Bit test, register indirect
      IBCS_OP_BIT_A8   = 4'h7,  // Bit test, 8-bit absolute
      IBCS_OP_BIT_A16  = 4'h8,  // Bit test, 16-bit absolute
      IBCS_OP_BIT_A32  = 4'h9,  // Bit test, 32-bit absolute
      IBCS_OP_BR8      = 4'hA,  // Branch, 8-bit displacement
      IBCS_OP_BR16     = 4'hB   // Branch, 16-bit displacement
   } ibcs_op_t;

   // Bus cycle kinds
   typedef enum logic [1:0] {
      IBCS_RD_BYTE = 2'h0,
      IBCS_RD_WORD = 2'h1,
      IBCS_WR_BYTE = 2'h2,
      IBCS_WR_WORD = 2'h3
   } ibcs_kind_t;

   localparam int          IBCS_ADDR_W     = 24;
   localparam logic [23:0] IBCS_WORD_STEP  = 24'h00_0002;
   localparam logic [23:0] IBCS_RESET_ADDR = 24'h00_0000;
   localparam logic [2:0]  IBCS_IDLE_STATES = 3'h1;

endpackage

/* rtl/ibcs_step.sv */
// Step decoder: bus action of one step of an instruction class
`timescale 1ns/1ps
`default_nettype none

module ibcs_step (
   input  wire logic [3:0] op,         // Instruction class
   input  wire logic [2:0] idx,        // Step index
   output logic            act,        // Step issues a bus cycle
   output logic            idle,       // Step is an internal state
   output logic [1:0]      src,        // 0 ext word, 1 ea, 2 next
   output logic            lock,       // Cycle is locked
   output logic            last        // Final step
);

   logic [2:0] n_ext;

   always_comb begin
      // Extension words before the operand byte of a bit test
      n_ext = (op == ibcs_pkg::IBCS_OP_BIT_A16) ? 3'd2 :
              (op == ibcs_pkg::IBCS_OP_BIT_A32) ? 3'd3 : 3'd1;
      act  = 1'b1;
      idle = 1'b0;
      src  = 2'd2;
      lock = 1'b0;
      last = 1'b0;
      unique case (ibcs_pkg::ibcs_op_t'(op))
         ibcs_pkg::IBCS_OP_IMM16, ibcs_pkg::IBCS_OP_AND_L, ibcs_pkg::IBCS_OP_AND_INTO_CONTROL_REGISTER_EXT: begin
            src  = (idx == 3'd0) ? 2'd0 : 2'd2;
            last = (idx == 3'd1);
         end
         ibcs_pkg::IBCS_OP_IMM32: begin
            src  = (idx < 3'd2) ? 2'd0 : 2'd2;
            last = (idx == 3'd2);
         end
         ibcs_pkg::IBCS_OP_BIT_IND, ibcs_pkg::IBCS_OP_BIT_A8,
         ibcs_pkg::IBCS_OP_BIT_A16, ibcs_pkg::IBCS_OP_BIT_A32: begin
            src  = (idx < n_ext) ? 2'd0 : (idx == n_ext) ? 2'd1 : 2'd2;
            lock = (idx == n_ext + 3'd1);
            last = (idx == n_ext + 3'd1);
         end
         ibcs_pkg::IBCS_OP_BR8: begin
            src  = (idx == 3'd0) ? 2'd2 : 2'd1;
            last = (idx == 3'd1);
         end
         ibcs_pkg::IBCS_OP_BR16: begin
            src  = (idx == 3'd0) ? 2'd0 : 2'd1;
            act  = (idx != 3'd1);
            idle = (idx == 3'd1);
            last = (idx == 3'd2);
         end
         default: begin
            last = 1'b1;
         end
      endcase
   end

endmodule

`default_nettype wire

/* verif/ibcs_mem.sv */
// Memory model: answers each bus cycle after a set number of wait cycles
`timescale 1ns/1ps
`default_nettype none

module ibcs_mem (
   input  wire logic       core_clk,    // System clock
   input  wire logic       rst_n,       // Async reset, active low
   input  wire logic       cyc_valid,   // Cycle requested by the core
   input  wire logic [3:0] wait_states, // Extra cycles before the answer
   output logic            cycle_done   // Current cycle ends this edge
);
   logic [3:0] cnt;
   logic [3:0] next_cnt;

   // Cycle length is set here, not by the sequencer
   always_comb begin
      next_cnt = cnt;
      if (cyc_valid) begin
         next_cnt = cycle_done ? 4'h0 : cnt + 4'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 4'h0;
      end else begin
         cnt <= next_cnt;
      end
   end

   always_comb begin
      cycle_done = cyc_valid && (cnt == wait_states);
   end
endmodule

`default_nettype wire

/* verif/testbench.sv */
// Testbench: runs each instruction class and checks the issued bus cycles
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam logic [1:0]  RW = ibcs_pkg::IBCS_RD_WORD;
   localparam logic [1:0]  RB = ibcs_pkg::IBCS_RD_BYTE;
   localparam logic [27:0] INT_ST = 28'h800_0000;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        start = 1'b0;
   logic [3:0]  op_class = 4'h0;
   logic [23:0] start_addr = 24'h00_0000;
   logic [23:0] effective_address = 24'h00_0000;
   logic        bus_req = 1'b0;
   logic [3:0]  wait_states = 4'h0;
   logic        cycle_done, busy, cyc_valid, cyc_lock, internal_op, bus_grant, instr_done;
   logic [1:0]  cyc_kind;
   logic [23:0] cyc_addr;
   logic [27:0] got_q[$];
   logic [27:0] exp_q[$];
   int          miscompares = 0;
   int          tests_run = 0;
   int          grant_bad = 0;

   always #5 core_clk = ~core_clk;

   ibcs_seq dut (.core_clk(core_clk), .rst_n(rst_n), .start(start), .op_class(op_class),
      .start_addr(start_addr), .effective_address(effective_address), .cycle_done(cycle_done),
      .bus_req(bus_req), .busy(busy), .cyc_valid(cyc_valid), .cyc_kind(cyc_kind),
      .cyc_addr(cyc_addr), .cyc_lock(cyc_lock), .internal_op(internal_op),
      .bus_grant(bus_grant), .instr_done(instr_done));
   ibcs_mem mem (.core_clk(core_clk), .rst_n(rst_n), .cyc_valid(cyc_valid),
      .wait_states(wait_states), .cycle_done(cycle_done));

   // ***************************************
   // Monitor: one entry per finished cycle
   // ***************************************
   always @(posedge core_clk) begin
      if (cyc_valid === 1'b1 && cycle_done === 1'b1) begin
         got_q.push_back({1'b0, cyc_lock, cyc_kind, cyc_addr});
      end
      if (internal_op === 1'b1) begin
         got_q.push_back(INT_ST);
      end
      if ((busy === 1'b1 || instr_done === 1'b1) && bus_grant !== 1'b0) begin
         grant_bad++;
      end
   end

   // ***************************************
   // Helpers
   // ***************************************
   task automatic finish_test();
      $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(string what, logic [27:0] seen, logic [27:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic ex(logic [1:0] kind, logic [23:0] addr, logic lk);
      exp_q.push_back({1'b0, lk, kind, addr});
   endtask

   task automatic words(logic [23:0] sa, int n);
      for (int i = 1; i <= n; i++) begin
         ex(RW, sa + 24'(2 * i), 1'b0);
      end
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (instr_done !== 1'b1) begin
         @(negedge core_clk);
         n++;
         if (n > 200) begin
            miscompares++;
            finish_test();
         end
      end
   endtask

   // Mode 1 retries start while busy, mode 2 raises bus_req after start
   task automatic issue(logic [3:0] op, logic [23:0] sa, logic [23:0] ea, logic [3:0] ws, int mode);
      got_q.delete();
      wait_states = ws;
      op_class = op;
      start_addr = sa;
      effective_address = ea;
      start = 1'b1;
      @(negedge core_clk);
      start = 1'b0;
      check("busy", {27'h000_0000, busy}, 28'h000_0001);
      if (mode == 2) begin
         bus_req = 1'b1;
      end
      if (mode == 1) begin
         @(negedge core_clk);
         op_class = ibcs_pkg::IBCS_OP_REG;
         start = 1'b1;
         @(negedge core_clk);
         start = 1'b0;
      end
      wait_done();
      check("busy after done", {27'h000_0000, busy}, 28'h000_0000);
      check("cycle count", 28'(got_q.size()), 28'(exp_q.size()));
      foreach (exp_q[i]) begin
         check("cycle entry", (i < got_q.size()) ? got_q[i] : 28'hxxx_xxxx, exp_q[i]);
      end
      exp_q.delete();
   endtask

   // ***************************************
   // Scenarios
   // ***************************************
   task automatic sc_single();
      words(24'h00_1000, 1);
      issue(ibcs_pkg::IBCS_OP_REG, 24'h00_1000, 24'h00_0000, 4'h0, 0);
      words(24'h00_1010, 1);
      issue(ibcs_pkg::IBCS_OP_AND_INTO_CONTROL_REGISTER_CC, 24'h00_1010, 24'h00_0000, 4'h2, 0);
   endtask

   task automatic sc_ext();
      words(24'h00_2000, 2);
      issue(ibcs_pkg::IBCS_OP_IMM16, 24'h00_2000, 24'h00_0000, 4'h0, 0);
      words(24'h00_FFFC, 3);
      issue(ibcs_pkg::IBCS_OP_IMM32, 24'h00_FFFC, 24'h00_0000, 4'h1, 0);
      words(24'h00_2100, 2);
      issue(ibcs_pkg::IBCS_OP_AND_L, 24'h00_2100, 24'h00_0000, 4'h0, 0);
      words(24'h00_2200, 2);
      issue(ibcs_pkg::IBCS_OP_AND_INTO_CONTROL_REGISTER_EXT, 24'h00_2200, 24'h00_0000, 4'h3, 0);
   endtask

   task automatic sc_bit();
      logic [3:0] ops[4] = '{ibcs_pkg::IBCS_OP_BIT_IND, ibcs_pkg::IBCS_OP_BIT_A8,
                             ibcs_pkg::IBCS_OP_BIT_A16, ibcs_pkg::IBCS_OP_BIT_A32};
      int         ext[4] = '{1, 1, 2, 3};
      for (int i = 0; i < 4; i++) begin
         words(24'h00_3000, ext[i]);
         ex(RB, 24'h00_8001, 1'b0);
         ex(RW, 24'h00_3000 + 24'(2 * (ext[i] + 1)), 1'b1);
         issue(ops[i], 24'h00_3000, 24'h00_8001, 4'(i), 0);
      end
   endtask

   task automatic sc_branch();
      ex(RW, 24'h00_4002, 1'b0);
      ex(RW, 24'h00_5000, 1'b0);
      issue(ibcs_pkg::IBCS_OP_BR8, 24'h00_4000, 24'h00_5000, 4'h3, 0);
      words(24'h00_4100, 1);
      exp_q.push_back(INT_ST);
      ex(RW, 24'h00_6000, 1'b0);
      issue(ibcs_pkg::IBCS_OP_BR16, 24'h00_4100, 24'h00_6000, 4'h1, 0);
   endtask

   task automatic sc_refuse();
      words(24'h00_7000, 3);
      issue(ibcs_pkg::IBCS_OP_IMM32, 24'h00_7000, 24'h00_0000, 4'h3, 1);
   endtask

   task automatic sc_lock();
      int n;
      grant_bad = 0;
      words(24'h00_3100, 1);
      ex(RB, 24'h00_9000, 1'b0);
      ex(RW, 24'h00_3104, 1'b1);
      issue(ibcs_pkg::IBCS_OP_BIT_IND, 24'h00_3100, 24'h00_9000, 4'h1, 2);
      check("grant while locked", 28'(grant_bad), 28'h000_0000);
      n = 0;
      while (bus_grant !== 1'b1 && n < 10) begin
         @(negedge core_clk);
         n++;
      end
      check("grant after idle", {27'h000_0000, bus_grant}, 28'h000_0001);
      bus_req = 1'b0;
      repeat (4) @(negedge core_clk);
      check("grant released", {27'h000_0000, bus_grant}, 28'h000_0000);
   endtask

   initial begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      rst_n = 1'b1;
      sc_single();
      sc_ext();
      sc_bit();
      sc_branch();
      sc_refuse();
      sc_lock();
      sc_single();
      finish_test();
   end
endmodule

`default_nettype wire
